//--- logic/unr_aes_stage.sv
`timescale 1ns/1ns
// Stand-in key-stream stage: XOR with a key word. A real AES core replaces it
// with the same one-cycle handshake; only the load path uses it.
module unr_aes_stage
  import unr_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 bypass_in,
  input  wire logic [BANK_BITS-1:0] key_in,
  input  wire logic [BANK_BITS-1:0] data_in,
  output logic      [BANK_BITS-1:0] data_out
);
  typedef struct packed {
    logic [BANK_BITS-1:0] data;
  } unr_aes_st_t;

  unr_aes_st_t st_reg;
  unr_aes_st_t st_next;

  always_comb begin
    st_next.data = bypass_in ? data_in : (data_in ^ key_in);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.data;
endmodule // unr_aes_stage

//--- logic/unr_pkg.sv
package unr_pkg;
  localparam int unsigned BANK_COUNT  = 8;
  localparam int unsigned BANK_BITS   = 128;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BYTES_BANK  = 16;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned BANK_SEL_W  = 3;
  localparam int unsigned BYTE_SEL_W  = 4;
  localparam int unsigned BANK_SEL_LO = 4;
  localparam int unsigned STORE_BITS  = BANK_COUNT * BANK_BITS;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [BANK_BITS-1:0] BANK_RESET = 128'h0;

  typedef enum logic [2:0] {
    UNR_IDLE   = 3'h1,
    UNR_SHIFT  = 3'h2,
    UNR_COMMIT = 3'h4
  } unr_prog_state_t;

  function automatic logic [2:0] unr_bank_of(input logic [6:0] addr);
    return addr[BANK_SEL_LO +: BANK_SEL_W];
  endfunction

  function automatic logic [3:0] unr_byte_of(input logic [6:0] addr);
    return addr[BYTE_SEL_W-1:0];
  endfunction
endpackage

//--- logic/unr_user_nvm_byte_reader.sv
`timescale 1ns/1ns
// Storage here is flip-flops standing in for the nonvolatile array; retention
// across power loss belongs to the cell technology, not to this logic.
// Limitation: reset clears the array, which a real part would keep.
module unr_user_nvm_byte_reader
  import unr_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Core read port, same clock as the requester
  input  wire logic                  rd_en_in,
  input  wire logic [ADDR_W-1:0]     rd_addr_in,
  output logic      [BYTE_W-1:0]     rd_data_out,
  output logic                       rd_valid_out,
  // Programming port, driven by the JTAG controller
  input  wire logic                  jt_erase_in,
  input  wire logic                  jt_load_in,
  input  wire logic [BANK_SEL_W-1:0] jt_bank_in,
  input  wire logic [BANK_BITS-1:0]  jt_data_in,
  input  wire logic                  jt_decrypt_in,
  input  wire logic [BANK_BITS-1:0]  jt_key_in,
  input  wire logic                  jt_rd_in,
  output logic      [BANK_BITS-1:0]  jt_rd_data_out,
  output logic                       jt_busy_out
);
  typedef struct packed {
    logic [BANK_COUNT-1:0][BANK_BITS-1:0] store;
    logic [BYTE_W-1:0]                    rd_data;
    logic                                 rd_valid;
    logic [BANK_BITS-1:0]                 jt_rd_data;
    unr_prog_state_t                      prog;
    logic [BANK_SEL_W-1:0]                prog_bank;
    logic                                 prog_erase;
    logic                                 busy;
  } unr_st_t;

  unr_st_t              st_reg;
  unr_st_t              st_next;
  logic [BANK_BITS-1:0] dec_data;

  unr_aes_stage u_aes (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .bypass_in (~jt_decrypt_in),
    .key_in    (jt_key_in),
    .data_in   (jt_data_in),
    .data_out  (dec_data)
  );

  always_comb begin
    st_next = st_reg;
    // Core read: one byte, bank from high bits, byte from low bits
    if (rd_en_in) begin
      st_next.rd_data = st_reg.store[unr_bank_of(rd_addr_in)]
                          [unr_byte_of(rd_addr_in)*BYTE_W +: BYTE_W];
    end
    st_next.rd_valid = rd_en_in;
    // JTAG readback of a whole bank
    if (jt_rd_in) begin
      st_next.jt_rd_data = st_reg.store[jt_bank_in];
    end
    // Programming sequencer; the only writer of the array
    case (st_reg.prog)
      UNR_IDLE: begin
        if (jt_erase_in || jt_load_in) begin
          st_next.prog       = UNR_SHIFT;
          st_next.prog_bank  = jt_bank_in;
          st_next.prog_erase = jt_erase_in;
        end
      end
      UNR_SHIFT: begin
        // Waits one cycle so the decrypt stage output is settled
        st_next.prog = UNR_COMMIT;
      end
      UNR_COMMIT: begin
        // Whole bank at once: the array has no byte-wide write path
        if (st_reg.prog_erase) begin
          st_next.store[st_reg.prog_bank] = BANK_RESET;
        end else begin
          st_next.store[st_reg.prog_bank] = dec_data;
        end
        st_next.prog = UNR_IDLE;
      end
      default: begin
        st_next.prog = UNR_IDLE;
      end
    endcase
    // Busy has its own flop so the pin carries no decode glitch
    st_next.busy = (st_next.prog != UNR_IDLE);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg.store      <= '0;
      st_reg.rd_data    <= BYTE_RESET;
      st_reg.rd_valid   <= 1'b0;
      st_reg.jt_rd_data <= BANK_RESET;
      st_reg.prog       <= UNR_IDLE;
      st_reg.prog_bank  <= '0;
      st_reg.prog_erase <= 1'b0;
      st_reg.busy       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out    = st_reg.rd_data;
  assign rd_valid_out   = st_reg.rd_valid;
  assign jt_rd_data_out = st_reg.jt_rd_data;
  assign jt_busy_out    = st_reg.busy;

  a_read_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_en_in && st_reg.prog == UNR_IDLE |=> rd_data_out ==
      $past(st_reg.store[unr_bank_of(rd_addr_in)][unr_byte_of(rd_addr_in)*BYTE_W +: BYTE_W]))
    else $error("read byte wrong one cycle after address");

  a_read_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !rd_en_in |=> $stable(rd_data_out))
    else $error("read byte changed without a new address");

  a_valid_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_en_in |=> rd_valid_out)
    else $error("read valid missing after access");

  a_no_core_write: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog == UNR_IDLE && !jt_erase_in && !jt_load_in |=> $stable(st_reg.store))
    else $error("store altered without a programming request");

  a_erase_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog == UNR_COMMIT && st_reg.prog_erase |=>
      st_reg.store[$past(st_reg.prog_bank)] == BANK_RESET)
    else $error("erased bank not cleared");

  a_prog_seq: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog == UNR_IDLE && (jt_erase_in || jt_load_in) |=>
      st_reg.prog == UNR_SHIFT ##1 st_reg.prog == UNR_COMMIT ##1 st_reg.prog == UNR_IDLE)
    else $error("programming sequence out of order");

  a_jtag_rdback: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_rd_in && st_reg.prog == UNR_IDLE |=> jt_rd_data_out == $past(st_reg.store[jt_bank_in]))
    else $error("jtag readback wrong");

  a_busy_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_load_in && !jt_busy_out |=> jt_busy_out [*2] ##1 !jt_busy_out)
    else $error("busy not held for two cycles");

  // Read port: one byte per access, answered one cycle later
  a_valid_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !rd_en_in
    |=> !rd_valid_out)
    else $error("read valid without an access");

  a_read_any: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_en_in
    |=> rd_data_out == $past(st_reg.store[rd_addr_in[ADDR_W-1:BANK_SEL_LO]]
      [rd_addr_in[BYTE_SEL_W-1:0]*BYTE_W +: BYTE_W]))
    else $error("read byte not taken from the addressed bank and byte");

  // Programming port: whole banks, only from the programming side
  a_commit_only: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog != UNR_COMMIT
    |=> $stable(st_reg.store))
    else $error("store written outside the commit step");

  a_load_writes: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog == UNR_COMMIT && !st_reg.prog_erase
    |=> st_reg.store[$past(st_reg.prog_bank)] == $past(dec_data))
    else $error("loaded bank does not hold the load data");

  a_decrypt_on: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_decrypt_in
    |=> dec_data == $past(jt_data_in ^ jt_key_in))
    else $error("decrypt stage output wrong");

  a_decrypt_off: assert property (@(posedge clk_in) disable iff (rst_in)
    !jt_decrypt_in
    |=> dec_data == $past(jt_data_in))
    else $error("bypassed load data altered");

  a_jtag_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !jt_rd_in
    |=> $stable(jt_rd_data_out))
    else $error("readback word changed without a request");

  a_jtag_any: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_rd_in
    |=> jt_rd_data_out == $past(st_reg.store[jt_bank_in]))
    else $error("readback word not the addressed bank");

  a_busy_erase: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_erase_in && !jt_busy_out
    |=> jt_busy_out [*2] ##1 !jt_busy_out)
    else $error("busy not held for two cycles on erase");

  a_busy_refuse: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_busy_out && (jt_erase_in || jt_load_in)
    |=> st_reg.prog != UNR_SHIFT)
    else $error("start accepted while busy");

  a_erase_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_erase_in && !jt_busy_out
    |=> st_reg.prog_erase)
    else $error("erase request not taken as erase");

  a_load_only: assert property (@(posedge clk_in) disable iff (rst_in)
    jt_load_in && !jt_erase_in && !jt_busy_out
    |=> !st_reg.prog_erase)
    else $error("load request taken as erase");

  a_bank_taken: assert property (@(posedge clk_in) disable iff (rst_in)
    (jt_erase_in || jt_load_in) && !jt_busy_out
    |=> st_reg.prog_bank == $past(jt_bank_in))
    else $error("programmed bank is not the requested one");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    !jt_busy_out && !jt_erase_in && !jt_load_in
    |=> !jt_busy_out)
    else $error("busy raised without a programming request");

  a_commit_ends: assert property (@(posedge clk_in) disable iff (rst_in)
    st_reg.prog == UNR_COMMIT
    |=> !jt_busy_out)
    else $error("busy still high after the commit step");
endmodule // unr_user_nvm_byte_reader

//--- sim/unr_core_model.sv
`timescale 1ns/1ns
// Requesting core logic; an idle address bus shows the inverse of its last value
module unr_core_model
  import unr_pkg::*;
(
  input  wire logic              req_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  output logic                   rd_en_out,
  output logic      [ADDR_W-1:0] rd_addr_out
);
  logic [ADDR_W-1:0] last_reg = 7'h00;
  always @(addr_in or req_in) if (req_in) last_reg = addr_in;
  assign rd_en_out   = req_in;
  assign rd_addr_out = req_in ? addr_in : ~last_reg;
endmodule // unr_core_model

//--- sim/unr_user_nvm_byte_reader_bench.sv
`timescale 1ns/1ns
module unr_user_nvm_byte_reader_bench;
  import unr_pkg::*;
  logic                 clk_in = 1'b0, rst_in = 1'b1, req = 1'b0, rd_en, rvld, busy;
  logic                 ld = 1'b0, er = 1'b0, dec = 1'b0, jrd = 1'b0;
  logic [ADDR_W-1:0]    addr = 7'h00, rd_addr;
  logic [BYTE_W-1:0]    rdat;
  logic [2:0]           bank = 3'h0;
  logic [BANK_BITS-1:0] din = '0, key = '0, jdat;
  logic [BANK_BITS-1:0] d = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  logic [BANK_BITS-1:0] k = 128'h55aa33cc0ff0a5a5123456789abcdef0;
  int                   mismatches = 0, num_checks = 0;
  initial forever #20 clk_in = ~clk_in;
  unr_core_model u_core (.req_in(req), .addr_in(addr), .rd_en_out(rd_en),
    .rd_addr_out(rd_addr));
  unr_user_nvm_byte_reader u_dut (.clk_in(clk_in), .rst_in(rst_in), .rd_en_in(rd_en),
    .rd_addr_in(rd_addr), .rd_data_out(rdat), .rd_valid_out(rvld), .jt_erase_in(er),
    .jt_load_in(ld), .jt_bank_in(bank), .jt_data_in(din), .jt_decrypt_in(dec),
    .jt_key_in(key), .jt_rd_in(jrd), .jt_rd_data_out(jdat), .jt_busy_out(busy));
  task automatic check(input logic [BANK_BITS-1:0] seen, input logic [BANK_BITS-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic prog(input logic e, input logic [2:0] b, input logic x,
                      input logic [BANK_BITS-1:0] v);
    @(negedge clk_in);
    er = e;
    // Load stays up on erase too, so every erase also shows that erase wins
    ld = 1'b1;
    bank = b;
    dec = x;
    din = v;
    @(negedge clk_in);
    er = 1'b0;
    ld = 1'b0;
    check(busy, 1'b1);
    repeat (2) @(negedge clk_in);
    check(busy, 1'b0);
    din = ~v;
  endtask
  task automatic jread(input logic [2:0] b, input logic [BANK_BITS-1:0] exp);
    @(negedge clk_in);
    jrd = 1'b1;
    bank = b;
    @(negedge clk_in);
    jrd = 1'b0;
    check(jdat, exp);
  endtask
  // A start while busy is dropped: bank 4 stays blank, bank 3 gets the bypassed data
  task automatic t_refuse();
    @(negedge clk_in);
    ld = 1'b1;
    bank = 3'h3;
    dec = 1'b0;
    din = d;
    @(negedge clk_in);
    bank = 3'h4;
    check(busy, 1'b1);
    @(negedge clk_in);
    ld = 1'b0;
    @(negedge clk_in);
    check(busy, 1'b0);
    jread(3'h4, '0);
    jread(3'h3, d);
    $display("refused start test done");
  endtask
  task automatic t_reset();
    @(negedge clk_in);
    rst_in = 1'b1;
    @(negedge clk_in);
    check(rvld, 1'b0);
    check(rdat, 8'h00);
    check(jdat, '0);
    check(busy, 1'b0);
    rst_in = 1'b0;
    jread(3'h2, '0);
    $display("mid-run reset test done");
  endtask
  // Back-to-back reads of all sixteen bytes; each answer is checked as the next goes out
  task automatic t_bytes(input logic [2:0] b, input logic [BANK_BITS-1:0] v);
    for (int i = 0; i <= 16; i++) begin
      @(negedge clk_in);
      if (i > 0) begin
        check(rdat, v[8*(i-1) +: 8]);
        check(rvld, 1'b1);
      end
      req = (i < 16);
      addr = {b, 4'(i)};
    end
    @(negedge clk_in);
    check(rvld, 1'b0);
    check(rdat, v[127:120]);
    $display("byte reads of bank %0d done", b);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    check(rvld, 1'b0);
    check(rdat, 8'h00);
    check(busy, 1'b0);
    check(jdat, '0);
    $display("reset test done");
    prog(1'b0, 3'h5, 1'b0, d);
    t_bytes(3'h5, d);
    jread(3'h5, d);
    prog(1'b0, 3'h2, 1'b1, d ^ k);
    key = k;
    prog(1'b0, 3'h2, 1'b1, d);
    jread(3'h2, d ^ k);
    t_bytes(3'h2, d ^ k);
    jread(3'h5, d);
    $display("decrypt test done");
    t_refuse();
    prog(1'b1, 3'h5, 1'b0, d);
    jread(3'h5, '0);
    jread(3'h2, d ^ k);
    $display("erase test done");
    t_reset();
    wrap_up();
  end
  // Whole sequence needs well under 300 cycles
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule // unr_user_nvm_byte_reader_bench
